// file: design/nhp_host.sv
/*
 * Host controller for a multiplexed NAND-style nonvolatile SRAM port:
 * runs command, address, data-in and data-out cycles from user requests.
 * Assumes pins are synchronous to clk, ready_busy is high when ready,
 * and the bidirectional data bus is resolved outside from dq_oe.
 */
`timescale 1ns/1ps
module nhp_host import nhp_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cfg_x16,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire nhp_rq_t cmd_op,
    input wire logic [20:0] cmd_addr,
    input wire logic [11:0] cmd_len,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [15:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [15:0] rd_data,
    input wire logic protect_req,
    input wire logic store_req,
    output logic ce_n,
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic read_strobe_n,
    output logic wp_n,
    output logic hw_store_n,
    output logic [15:0] dq_o,
    output logic dq_oe,
    input wire logic [15:0] dq_i,
    input wire logic ready_busy
);
    nhp_st_t st_r, st_nxt;
    nhp_ph_t ph_r, ph_nxt;
    nhp_rq_t op_r, op_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [2:0] byte_r, byte_nxt;
    logic [11:0] len_r, len_nxt;
    logic [20:0] addr_r, addr_nxt;
    logic ce_n_r, ce_n_nxt, cle_r, cle_nxt, ale_r, ale_nxt;
    logic we_n_r, we_n_nxt, rs_n_r, rs_n_nxt, dq_oe_r, dq_oe_nxt;
    logic [15:0] dq_o_r, dq_o_nxt;
    logic cmd_ready_r, cmd_ready_nxt, wr_ready_r, wr_ready_nxt, taken_r, taken_nxt;
    logic wp_n_r, hw_store_n_r;
    logic go, done, buf_push, buf_ready;

    // address byte layout, zero fill, top bit low in x16
    function automatic logic [7:0] addr_byte(input logic [20:0] a, input logic [2:0] idx, input logic x16);
        case (idx)
            3'h0: addr_byte = a[7:0];
            3'h1: addr_byte = a[15:8];
            3'h2: addr_byte = {3'h0, a[20] & ~x16, a[19:16]};
            default: addr_byte = 8'h00;
        endcase
    endfunction : addr_byte

    always_comb begin
        st_nxt = st_r;
        ph_nxt = ph_r;
        op_nxt = op_r;
        cnt_nxt = cnt_r;
        byte_nxt = byte_r;
        len_nxt = len_r;
        addr_nxt = addr_r;
        ce_n_nxt = ce_n_r;
        cle_nxt = cle_r;
        ale_nxt = ale_r;
        we_n_nxt = we_n_r;
        rs_n_nxt = rs_n_r;
        dq_oe_nxt = dq_oe_r;
        dq_o_nxt = dq_o_r;
        cmd_ready_nxt = 1'b0;
        wr_ready_nxt = 1'b0;
        taken_nxt = taken_r;
        go = 1'b1;
        done = 1'b0;
        buf_push = 1'b0;
        case (st_r)
            ST_IDLE: begin
                ce_n_nxt = 1'b1;
                dq_oe_nxt = 1'b0;
                cmd_ready_nxt = !(cmd_valid && cmd_ready_r);
                if (cmd_valid && cmd_ready_r) begin
                    op_nxt = cmd_op;
                    addr_nxt = cmd_addr;
                    len_nxt = cmd_len;
                    ce_n_nxt = 1'b0;
                    cnt_nxt = CNT_W'(T_SU_CYC);
                    ph_nxt = PH_SETUP;
                    // only status and reset may go out while busy
                    st_nxt = (cmd_op == NHP_RQ_STATUS || cmd_op == NHP_RQ_RESET) ? ST_CMD1 : ST_WAIT_RDY;
                end
            end
            ST_WAIT_RDY: begin
                if (ready_busy) begin
                    st_nxt = ST_CMD1;
                    cnt_nxt = CNT_W'(T_SU_CYC);
                end
            end
            ST_CMD1, ST_CMD2: begin
                // command byte on the low lane with command latch
                cle_nxt = 1'b1;
                ale_nxt = 1'b0;
                dq_oe_nxt = 1'b1;
                dq_o_nxt = {8'h00, (st_r == ST_CMD1) ? first_op(op_r) : second_op(op_r)};
            end
            ST_ADDR: begin
                // address bytes low first on the low lane
                cle_nxt = 1'b0;
                ale_nxt = 1'b1;
                dq_oe_nxt = 1'b1;
                dq_o_nxt = {8'h00, addr_byte(addr_r, byte_r, cfg_x16)};
            end
            ST_DIN: begin
                cle_nxt = 1'b0;
                ale_nxt = 1'b0;
                dq_oe_nxt = 1'b1;
                go = taken_r;
                if (wr_valid && wr_ready_r) begin
                    taken_nxt = 1'b1;
                    dq_o_nxt = cfg_x16 ? wr_data : {8'h00, wr_data[7:0]};
                end else begin
                    wr_ready_nxt = !taken_r;
                end
            end
            ST_WB: begin
                if (cnt_r != '0) begin
                    cnt_nxt = cnt_r - 1'b1;
                end else begin
                    st_nxt = ST_WAIT_BUSY;
                end
            end
            ST_WAIT_BUSY: begin
                // no read strobe until ready/busy is released
                if (ready_busy) begin
                    cnt_nxt = CNT_W'(T_SU_CYC);
                    st_nxt = (op_r == NHP_RQ_READ || op_r == NHP_RQ_READ_ID || op_r == NHP_RQ_PARAM) ? ST_DOUT : ST_DONE;
                end
            end
            ST_DOUT: begin
                // stall read strobes while the buffer is full
                cle_nxt = 1'b0;
                ale_nxt = 1'b0;
                dq_oe_nxt = 1'b0;
                go = buf_ready;
            end
            ST_DONE: begin
                ce_n_nxt = 1'b1;
                cle_nxt = 1'b0;
                ale_nxt = 1'b0;
                dq_oe_nxt = 1'b0;
                st_nxt = ST_IDLE;
            end
            default: st_nxt = ST_IDLE;
        endcase
        // Strobe sequencer shared by all bus cycles
        if (st_r == ST_CMD1 || st_r == ST_CMD2 || st_r == ST_ADDR || st_r == ST_DIN || st_r == ST_DOUT) begin
            case (ph_r)
                PH_SETUP: begin
                    if (cnt_r != '0) begin
                        cnt_nxt = cnt_r - 1'b1;
                    end else if (go) begin
                        // only one strobe low per cycle
                        we_n_nxt = (st_r == ST_DOUT);
                        rs_n_nxt = (st_r != ST_DOUT);
                        cnt_nxt = CNT_W'(T_LO_CYC - 1);
                        ph_nxt = PH_LO;
                    end
                end
                PH_LO: begin
                    if (cnt_r != '0) begin
                        cnt_nxt = cnt_r - 1'b1;
                    end else begin
                        we_n_nxt = 1'b1;
                        rs_n_nxt = 1'b1;
                        buf_push = (st_r == ST_DOUT);
                        cnt_nxt = CNT_W'(T_HI_CYC - 1);
                        ph_nxt = PH_HI;
                    end
                end
                PH_HI: begin
                    if (cnt_r != '0) begin
                        cnt_nxt = cnt_r - 1'b1;
                    end else begin
                        done = 1'b1;
                        ph_nxt = PH_SETUP;
                        cnt_nxt = CNT_W'(T_SU_CYC);
                    end
                end
                default: ph_nxt = PH_SETUP;
            endcase
        end
        if (done) begin
            case (st_r)
                ST_CMD1: begin
                    byte_nxt = 3'h0;
                    if (addr_bytes(op_r) != 3'h0) begin
                        st_nxt = ST_ADDR;
                    end else if (op_r == NHP_RQ_STORE) begin
                        st_nxt = ST_CMD2;
                    end else if (op_r == NHP_RQ_STATUS) begin
                        st_nxt = ST_DOUT;
                    end else begin
                        st_nxt = ST_WB;
                        cnt_nxt = CNT_W'(T_WB_CYC);
                    end
                end
                ST_ADDR: begin
                    byte_nxt = byte_r + 3'h1;
                    if (byte_r == addr_bytes(op_r) - 3'h1) begin
                        // read confirm follows the address, write data follows
                        if (op_r == NHP_RQ_READ) begin
                            st_nxt = ST_CMD2;
                        end else if (op_r == NHP_RQ_WRITE) begin
                            st_nxt = ST_DIN;
                        end else begin
                            st_nxt = ST_WB;
                            cnt_nxt = CNT_W'(T_WB_CYC);
                        end
                    end
                end
                ST_DIN: begin
                    taken_nxt = 1'b0;
                    len_nxt = len_r - 12'h001;
                    st_nxt = (len_r <= 12'h001) ? ST_CMD2 : ST_DIN;
                end
                ST_CMD2: begin
                    st_nxt = ST_WB;
                    cnt_nxt = CNT_W'(T_WB_CYC);
                end
                ST_DOUT: begin
                    len_nxt = len_r - 12'h001;
                    st_nxt = (len_r <= 12'h001) ? ST_DONE : ST_DOUT;
                end
                default: st_nxt = ST_DONE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= ST_IDLE;
            ph_r <= PH_SETUP;
            op_r <= NHP_RQ_STATUS;
            cnt_r <= '0;
            byte_r <= 3'h0;
            len_r <= LEN_RST;
            addr_r <= '0;
            ce_n_r <= 1'b1;
            cle_r <= 1'b0;
            ale_r <= 1'b0;
            we_n_r <= 1'b1;
            rs_n_r <= 1'b1;
            dq_oe_r <= 1'b0;
            dq_o_r <= 16'h0000;
            cmd_ready_r <= 1'b0;
            wr_ready_r <= 1'b0;
            taken_r <= 1'b0;
            wp_n_r <= 1'b1;
            hw_store_n_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            ph_r <= ph_nxt;
            op_r <= op_nxt;
            cnt_r <= cnt_nxt;
            byte_r <= byte_nxt;
            len_r <= len_nxt;
            addr_r <= addr_nxt;
            ce_n_r <= ce_n_nxt;
            cle_r <= cle_nxt;
            ale_r <= ale_nxt;
            we_n_r <= we_n_nxt;
            rs_n_r <= rs_n_nxt;
            dq_oe_r <= dq_oe_nxt;
            dq_o_r <= dq_o_nxt;
            cmd_ready_r <= cmd_ready_nxt;
            wr_ready_r <= wr_ready_nxt;
            taken_r <= taken_nxt;
            wp_n_r <= !protect_req;
            hw_store_n_r <= !store_req;
        end
    end

    nhp_skid u_skid (
        .clk(clk),
        .nrst(nrst),
        .in_valid(buf_push),
        .in_ready(buf_ready),
        .in_data(cfg_x16 ? dq_i : {8'h00, dq_i[7:0]}),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );

    assign cmd_ready = cmd_ready_r;
    assign wr_ready = wr_ready_r;
    assign ce_n = ce_n_r;
    assign cle = cle_r;
    assign ale = ale_r;
    assign we_n = we_n_r;
    assign read_strobe_n = rs_n_r;
    assign wp_n = wp_n_r;
    assign hw_store_n = hw_store_n_r;
    assign dq_o = dq_o_r;
    assign dq_oe = dq_oe_r;

    deselect_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
        ce_n_r |-> (we_n_r && rs_n_r && !dq_oe_r)) else $error("strobe or drive while deselected");
    latch_excl_a: assert property (@(posedge clk) disable iff (!nrst)
        !(cle_r && ale_r)) else $error("both latch enables high");
    strobe_excl_a: assert property (@(posedge clk) disable iff (!nrst)
        !(!we_n_r && !rs_n_r)) else $error("both strobes low");
    cmd_driven_a: assert property (@(posedge clk) disable iff (!nrst)
        (cle_r && !we_n_r) |-> (dq_oe_r && !ce_n_r && rs_n_r)) else $error("command cycle malformed");
    we_width_a: assert property (@(posedge clk) disable iff (!nrst)
        $fell(we_n_r) |-> (!we_n_r)[*4] ##1 we_n_r) else $error("write strobe low width wrong");
    addr_first_a: assert property (@(posedge clk) disable iff (!nrst)
        (ale_r && !we_n_r && byte_r == 3'h0) |-> dq_o_r[7:0] == addr_r[7:0]) else $error("first address byte wrong");
    addr_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        (ale_r && !we_n_r && byte_r >= 3'h3) |-> dq_o_r == 16'h0000) else $error("upper address bytes not zero");
    top_bit_low_a: assert property (@(posedge clk) disable iff (!nrst)
        (ale_r && !we_n_r && byte_r == 3'h2 && cfg_x16) |-> !dq_o_r[4]) else $error("top address bit high in x16");
    read_push_a: assert property (@(posedge clk) disable iff (!nrst)
        $fell(rs_n_r) |-> ##3 buf_push ##1 rs_n_r) else $error("read word not captured at strobe end");
    busy_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == ST_WAIT_RDY && !ready_busy) |=> st_r == ST_WAIT_RDY) else $error("command sent while busy");
endmodule : nhp_host

// file: design/nhp_pkg.sv
/*
 * Shared constants and types for the NAND-style host port controller:
 * opcodes, strobe timing in ns and clock cycles, request codes and states.
 * Assumes a single 125 MHz clock; all timing counts derive from CLK_NS.
 */
package nhp_pkg;

    localparam int CLK_NS = 8;

    function automatic int ns2cyc_up(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns2cyc_up

    // Strobe setup, strobe low, strobe high, wait before ready/busy is valid
    localparam int T_SU_NS = 10;
    localparam int T_LO_NS = 32;
    localparam int T_HI_NS = 16;
    localparam int T_WB_NS = 100;
    localparam int T_SU_CYC = ns2cyc_up(T_SU_NS);
    localparam int T_LO_CYC = ns2cyc_up(T_LO_NS);
    localparam int T_HI_CYC = ns2cyc_up(T_HI_NS);
    localparam int T_WB_CYC = ns2cyc_up(T_WB_NS);
    localparam int CNT_W = 5;

    localparam logic [2:0] ADDR_BYTES = 3'h5;
    localparam logic [2:0] ID_ADDR_BYTES = 3'h1;
    localparam logic [11:0] LEN_RST = 12'h001;

    localparam logic [7:0] OP_READ1 = 8'h00;
    localparam logic [7:0] OP_READ2 = 8'h30;
    localparam logic [7:0] OP_WRITE1 = 8'h80;
    localparam logic [7:0] OP_WRITE2 = 8'h10;
    localparam logic [7:0] OP_STATUS = 8'h70;
    localparam logic [7:0] OP_RESET = 8'hFF;
    localparam logic [7:0] OP_READ_ID = 8'h90;
    localparam logic [7:0] OP_PARAM = 8'hEC;
    localparam logic [7:0] OP_RECALL = 8'hFC;
    localparam logic [7:0] OP_STORE1 = 8'h84;
    localparam logic [7:0] OP_STORE2 = 8'hA5;
    localparam logic [7:0] OP_AS_DIS = 8'hA3;
    localparam logic [7:0] OP_AS_EN = 8'hAC;

    typedef enum logic [3:0] {
        NHP_RQ_READ, NHP_RQ_WRITE, NHP_RQ_STATUS, NHP_RQ_READ_ID, NHP_RQ_PARAM,
        NHP_RQ_RESET, NHP_RQ_STORE, NHP_RQ_RECALL, NHP_RQ_AS_DIS, NHP_RQ_AS_EN
    } nhp_rq_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_WAIT_RDY, ST_CMD1, ST_ADDR, ST_DIN, ST_CMD2, ST_WB, ST_WAIT_BUSY, ST_DOUT, ST_DONE
    } nhp_st_t;

    typedef enum logic [1:0] {PH_SETUP, PH_LO, PH_HI} nhp_ph_t;

    function automatic logic [7:0] first_op(input nhp_rq_t rq);
        case (rq)
            NHP_RQ_READ: first_op = OP_READ1;
            NHP_RQ_WRITE: first_op = OP_WRITE1;
            NHP_RQ_STATUS: first_op = OP_STATUS;
            NHP_RQ_READ_ID: first_op = OP_READ_ID;
            NHP_RQ_PARAM: first_op = OP_PARAM;
            NHP_RQ_STORE: first_op = OP_STORE1;
            NHP_RQ_RECALL: first_op = OP_RECALL;
            NHP_RQ_AS_DIS: first_op = OP_AS_DIS;
            NHP_RQ_AS_EN: first_op = OP_AS_EN;
            default: first_op = OP_RESET;
        endcase
    endfunction : first_op

    function automatic logic [7:0] second_op(input nhp_rq_t rq);
        case (rq)
            NHP_RQ_READ: second_op = OP_READ2;
            NHP_RQ_WRITE: second_op = OP_WRITE2;
            default: second_op = OP_STORE2;
        endcase
    endfunction : second_op

    function automatic logic [2:0] addr_bytes(input nhp_rq_t rq);
        case (rq)
            NHP_RQ_READ, NHP_RQ_WRITE: addr_bytes = ADDR_BYTES;
            NHP_RQ_READ_ID, NHP_RQ_PARAM: addr_bytes = ID_ADDR_BYTES;
            default: addr_bytes = 3'h0;
        endcase
    endfunction : addr_bytes

endpackage : nhp_pkg

// file: design/nhp_skid.sv
/*
 * Two-entry buffer with valid/ready on both sides; outputs are registered.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module nhp_skid (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [15:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [15:0] out_data
);
    logic out_valid_r, out_valid_nxt, skid_valid_r, skid_valid_nxt;
    logic [15:0] out_data_r, out_data_nxt, skid_data_r, skid_data_nxt;
    logic push;

    always_comb begin
        push = in_valid && !skid_valid_r;
        out_valid_nxt = out_valid_r;
        out_data_nxt = out_data_r;
        skid_valid_nxt = skid_valid_r;
        skid_data_nxt = skid_data_r;
        if (!out_valid_r || out_ready) begin
            if (skid_valid_r) begin
                out_valid_nxt = 1'b1;
                out_data_nxt = skid_data_r;
                skid_valid_nxt = 1'b0;
            end else begin
                out_valid_nxt = push;
                out_data_nxt = push ? in_data : out_data_r;
            end
        end else if (push) begin
            skid_valid_nxt = 1'b1;
            skid_data_nxt = in_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_valid_r <= 1'b0;
            out_data_r <= 16'h0000;
            skid_valid_r <= 1'b0;
            skid_data_r <= 16'h0000;
        end else begin
            out_valid_r <= out_valid_nxt;
            out_data_r <= out_data_nxt;
            skid_valid_r <= skid_valid_nxt;
            skid_data_r <= skid_data_nxt;
        end
    end

    assign in_ready = !skid_valid_r;
    assign out_valid = out_valid_r;
    assign out_data = out_data_r;
endmodule : nhp_skid

// file: testbench/nhp_dev.sv
/* Behavioural model of the memory device behind the host port.
   Assumes pins come from nhp_host and data on dq_o is valid while it writes. */
`timescale 1ns/1ps
module nhp_dev (
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic read_strobe_n,
    input wire logic wp_n,
    input wire logic [15:0] dq_o,
    output logic [15:0] dq_i,
    output logic ready_busy
);
    // Status word with ready bits set; value arbitrary
    localparam logic [15:0] STAT = 16'h00C0;
    logic [7:0] cmdq[$];
    logic [7:0] adrq[$];
    logic [15:0] mem[int];
    logic [20:0] ptr = 21'h0;
    logic [15:0] q = 16'h0;
    logic oe = 1'b0;
    int busy_ns = 200;
    initial ready_busy = 1'b1;
    assign dq_i = (oe && !ce_n) ? q : ~q;
    always @(posedge we_n) begin
        if (!ce_n && read_strobe_n && cle && !ale && (ready_busy || dq_o[7:0] inside {8'h70, 8'hFF})) begin
            cmdq.push_back(dq_o[7:0]);
            if (dq_o[7:0] inside {8'h00, 8'h80, 8'hFF}) adrq.delete();
            if (!(dq_o[7:0] inside {8'h00, 8'h80, 8'h84, 8'h70})) begin
                ready_busy <= 1'b0;
                ready_busy <= #(busy_ns) 1'b1;
            end
        end else if (!ce_n && read_strobe_n && ale && !cle && ready_busy) begin
            adrq.push_back(dq_o[7:0]);
            if (adrq.size() == 3) ptr = {adrq[2][4:0], adrq[1], adrq[0]};
        end else if (!ce_n && read_strobe_n && !ale && !cle && ready_busy && wp_n) begin
            mem[ptr] = dq_o;
            ptr++;
        end
    end
    always @(negedge read_strobe_n) begin
        if (!ce_n && !cle && !ale && we_n && (ready_busy || (cmdq.size() > 0 && cmdq[$] == 8'h70))) begin
            q = (cmdq.size() > 0 && cmdq[$] == 8'h70) ? STAT : (mem.exists(ptr) ? mem[ptr] : 16'h0);
            ptr++;
            oe = 1'b1;
        end
    end
    always @(posedge read_strobe_n) oe <= #10 1'b0;
endmodule : nhp_dev

// file: testbench/nhp_host_tb.sv
/* Self-checking bench for nhp_host against the device model.
   Assumes a 125 MHz clock; cfg_x16 is high, then low for a last x8 pass. */
`timescale 1ns/1ps
module nhp_host_tb import nhp_pkg::*;;
    logic clk, nrst, cfg_x16, cmd_valid, wr_valid, rd_ready, protect_req, store_req;
    logic cmd_ready, wr_ready, rd_valid, ce_n, cle, ale, we_n, read_strobe_n, wp_n, hw_store_n, dq_oe, ready_busy;
    nhp_rq_t cmd_op;
    logic [20:0] cmd_addr;
    logic [11:0] cmd_len;
    logic [15:0] wr_data, rd_data, dq_o, dq_i;
    logic [15:0] wq[$];
    logic [15:0] rq[$];
    int err_count = 0;
    int cmp_count = 0;
    nhp_host i_dut (.clk, .nrst, .cfg_x16, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_len,
        .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_ready, .rd_data, .protect_req, .store_req, .ce_n,
        .cle, .ale, .we_n, .read_strobe_n, .wp_n, .hw_store_n, .dq_o, .dq_oe, .dq_i, .ready_busy);
    // Bus shows unknown unless the host enables its drivers
    nhp_dev i_dev (.ce_n, .cle, .ale, .we_n, .read_strobe_n, .wp_n, .dq_o(dq_oe ? dq_o : 16'hXXXX), .dq_i,
        .ready_busy);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Feeds write words, collects read words
    always @(posedge clk) begin
        if (wr_valid && wr_ready) void'(wq.pop_front());
        wr_valid <= (wq.size() > 0);
        wr_data <= (wq.size() > 0) ? wq[0] : 16'h0;
        if (rd_valid && rd_ready) rq.push_back(rd_data);
    end
    task check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task chk_q(input logic [7:0] got[$], input logic [7:0] exp[$]);
        check(16'(got.size()), 16'(exp.size()));
        foreach (exp[k]) check({8'h0, got[k]}, {8'h0, exp[k]});
    endtask : chk_q
    task automatic req(input nhp_rq_t op, input logic [20:0] a, input logic [11:0] n);
        int i;
        i_dev.cmdq.delete();
        i_dev.adrq.delete();
        rq.delete();
        @(posedge clk);
        cmd_op <= op;
        cmd_addr <= a;
        cmd_len <= n;
        cmd_valid <= 1'b1;
        @(posedge clk);
        while (cmd_ready !== 1'b1) @(posedge clk);
        cmd_valid <= 1'b0;
        repeat (2) @(posedge clk);
        i = 0;
        while (cmd_ready !== 1'b1 && i < 5000) begin
            @(posedge clk);
            i++;
        end
        check(16'(i < 5000), 16'h1);
        repeat (4) @(posedge clk);
    endtask : req
    task t_write;
        wq = '{16'hA55A, 16'h1234, 16'hBEEF};
        req(NHP_RQ_WRITE, 21'h1F0102, 12'h003);
        chk_q(i_dev.cmdq, '{OP_WRITE1, OP_WRITE2});
        chk_q(i_dev.adrq, '{8'h02, 8'h01, 8'h0F, 8'h00, 8'h00});
        check(i_dev.mem[21'h0F0102], 16'hA55A);
        check(i_dev.mem[21'h0F0104], 16'hBEEF);
        $display("test write done");
    endtask : t_write
    task t_read;
        rd_ready <= 1'b0;
        fork
            begin
                repeat (300) @(posedge clk);
                check(16'(rd_valid), 16'h1);
                rd_ready <= 1'b1;
            end
        join_none
        req(NHP_RQ_READ, 21'h1F0102, 12'h003);
        check(16'(rq.size()), 16'h3);
        check(rq[0], 16'hA55A);
        check(rq[1], 16'h1234);
        check(rq[2], 16'hBEEF);
        chk_q(i_dev.cmdq, '{OP_READ1, OP_READ2});
        $display("test read done");
    endtask : t_read
    task t_prot;
        protect_req <= 1'b1;
        store_req <= 1'b1;
        repeat (3) @(posedge clk);
        check({14'h0, wp_n, hw_store_n}, 16'h0);
        store_req <= 1'b0;
        wq = '{16'h0000};
        req(NHP_RQ_WRITE, 21'h0F0102, 12'h001);
        protect_req <= 1'b0;
        check(i_dev.mem[21'h0F0102], 16'hA55A);
        $display("test protect done");
    endtask : t_prot
    task automatic t_ops;
        nhp_rq_t ops[7] = '{NHP_RQ_READ_ID, NHP_RQ_PARAM, NHP_RQ_STORE, NHP_RQ_RECALL, NHP_RQ_AS_DIS,
            NHP_RQ_AS_EN, NHP_RQ_RESET};
        logic [7:0] exp[7] = '{OP_READ_ID, OP_PARAM, OP_STORE1, OP_RECALL, OP_AS_DIS, OP_AS_EN, OP_RESET};
        foreach (ops[k]) begin
            i_dev.busy_ns = (k % 2) ? 40 : 400;
            req(ops[k], 21'h000020, 12'h001);
            check({8'h0, i_dev.cmdq[0]}, {8'h0, exp[k]});
            if (ops[k] == NHP_RQ_STORE) check({8'h0, i_dev.cmdq[1]}, {8'h0, OP_STORE2});
        end
        // Device held busy: status goes out at once, NHP_RQ_AS_EN waits
        i_dev.ready_busy <= 1'b0;
        i_dev.ready_busy <= #1000 1'b1;
        req(NHP_RQ_STATUS, 21'h0, 12'h001);
        check(rq[0], 16'h00C0);
        req(NHP_RQ_AS_EN, 21'h0, 12'h001);
        chk_q(i_dev.cmdq, '{OP_AS_EN});
        $display("test opcodes done");
    endtask : t_ops
    task t_x8;
        cfg_x16 <= 1'b0;
        wq = '{16'hABCD};
        req(NHP_RQ_WRITE, 21'h1F0200, 12'h001);
        chk_q(i_dev.adrq, '{8'h00, 8'h02, 8'h1F, 8'h00, 8'h00});
        check(i_dev.mem[21'h1F0200], 16'h00CD);
        req(NHP_RQ_READ, 21'h1F0200, 12'h001);
        check(rq[0], 16'h00CD);
        $display("test x8 done");
    endtask : t_x8
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    initial begin
        nrst = 1'b0;
        cfg_x16 = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = NHP_RQ_STATUS;
        cmd_addr = 21'h0;
        cmd_len = 12'h0;
        wr_valid = 1'b0;
        wr_data = 16'h0;
        rd_ready = 1'b1;
        protect_req = 1'b0;
        store_req = 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        t_write;
        t_read;
        t_prot;
        t_ops;
        t_x8;
        finish_test;
    end
    initial begin
        #500000;
        err_count++;
        finish_test;
    end
endmodule : nhp_host_tb
